// ---- rtl/flp_poll_arbiter.v ----
// polling arbiter: highest programmed level wins, lowest poll index breaks ties
module flp_poll_arbiter #(
  parameter NGRP = 6
) (
  input  wire [2*NGRP-1:0] request,
  input  wire [NGRP-1:0]   levelLow,
  input  wire [NGRP-1:0]   levelHigh,
  output reg               found,
  output reg  [3:0]        winIndex,
  output reg  [1:0]        winLevel
);
  integer lv;
  integer i;

  // level of the group that holds poll index idx
  function [1:0] groupLevel;
    input [3:0]      idx;
    input [NGRP-1:0] lo;
    input [NGRP-1:0] hi;
    begin
      groupLevel = {hi[idx[3:1]], lo[idx[3:1]]};
    end
  endfunction

  // later hits override: higher level last, lower index last within a level
  always @* begin
    found    = 1'b0;
    winIndex = 4'h0;
    winLevel = 2'b00;
    for (lv = 0; lv < 4; lv = lv + 1) begin
      for (i = 2*NGRP-1; i >= 0; i = i - 1) begin
        if (request[i] && groupLevel(i[3:0], levelLow, levelHigh) == lv[1:0]) begin
          found    = 1'b1;
          winIndex = i[3:0];
          winLevel = lv[1:0];
        end
      end
    end
  end
endmodule // flp_poll_arbiter

// ---- rtl/flp_prioritizer.v ----
// four-level interrupt prioritizer with axi4-lite registers
// What this block does
// - serial transmit flag set on transmit done, cleared only by software.
// - serial receive flag set on byte received, cleared only by software.
// - serial request is receive OR transmit; vectoring clears neither.
// - group level is high-register bit and low-register bit, 11 highest.
// - six groups pair a higher-ranked and lower-ranked source.
// - only strictly higher level or wake-up preempts; top level only by wake-up.
// - highest programmed level among pending requests is serviced first.
// - equal levels: higher-ranked source first, groups scanned one to six.
// - flags sampled at sample point, evaluated in following machine cycle.
// - call blocked by busy level, non-final cycle, return or int-register write.
// - after return or int-register write one more instruction runs first.
// - blocked requests are not remembered; only current samples count.
// - acknowledge issues long call: push pc, no status word save, load vector.
// - fixed vector address per source, wake-up at 0x007b.
// - external 0 and 1 flags cleared on vector only when edge-triggered.
// - higher request sampled during a lower call is vectored right after it.
// - return ends in-progress state of current level; core pops two bytes.
// - software writes set or clear flags like hardware, except level ext0/1.
`include "flp_regs.vh"

module flp_prioritizer #(
  parameter ADDR_W = 12
) (
  input  wire              clk,
  input  wire              rst,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output reg               irq,
  input  wire              samplePoint,
  input  wire              pollPoint,
  input  wire              lastCycle,
  input  wire              instrIsReti,
  input  wire              instrWritesIntReg,
  input  wire              retiExec,
  input  wire              wakeUpReq,
  output reg               longCallReq,
  output reg  [15:0]       vectorAddr,
  input  wire              serialTxDone,
  input  wire              serialRxDone,
  input  wire              timer0Ovf,
  input  wire              timer1Ovf,
  input  wire              timer2Ovf,
  input  wire              timer2Reload,
  input  wire              converterDone,
  input  wire [4:0]        extEvent,
  input  wire              ext0PinN,
  input  wire              ext1PinN
);
  reg  [7:0]        serialCtrl;
  reg  [5:0]        prioLow;
  reg  [5:0]        prioHigh;
  reg  [7:0]        enableA;
  reg  [5:0]        enableB;
  reg  [11:0]       reqFlags;
  reg  [1:0]        extEdge;
  reg  [2:0]        irqStatus;
  reg  [2:0]        irqMask;
  reg  [3:0]        inProgress;
  reg  [11:0]       sampled;
  reg               wakeSampled;
  reg               busHold;
  reg               ext0Prev;
  reg               ext1Prev;
  reg               awHeld;
  reg               wHeld;
  reg  [ADDR_W-1:0] awAddr;
  reg  [31:0]       wData;
  reg  [3:0]        wStrb;
  reg  [7:0]        next_serialCtrl;
  reg  [11:0]       next_reqFlags;
  reg  [3:0]        next_inProgress;
  reg  [2:0]        next_irqStatus;
  reg  [2:0]        next_irqMask;
  reg  [31:0]       readData;
  wire [11:0]       srcRaw;
  wire [11:0]       srcEn;
  wire [11:0]       events;
  wire [11:0]       vecClear;
  wire              found;
  wire [3:0]        winIndex;
  wire [1:0]        winLevel;

  // register index of a byte address; zero (unmapped) when out of range or unaligned
  function [7:0] indexOf;
    input [ADDR_W-1:0] addr;
    begin
      if (addr[ADDR_W-1:10] == 0 && addr[1:0] == 2'b00)
        indexOf = addr[9:2];
      else
        indexOf = 8'h00;
    end
  endfunction

  function isMapped;
    input [7:0] idx;
    begin
      case (idx)
        `FLP_IDX_SERIAL, `FLP_IDX_PRIO_LOW, `FLP_IDX_PRIO_HIGH, `FLP_IDX_ENABLE_A,
        `FLP_IDX_ENABLE_B, `FLP_IDX_REQ_FLAGS, `FLP_IDX_EXT_CTRL, `FLP_IDX_IRQ_STATUS,
        `FLP_IDX_IRQ_MASK, `FLP_IDX_CORE_STATE: isMapped = 1'b1;
        default: isMapped = 1'b0;
      endcase
    end
  endfunction

  // byte-lane merge for registers up to 16 bits wide
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] data;
    input [1:0]  strb;
    begin
      merge16 = (old & ~{{8{strb[1]}}, {8{strb[0]}}}) | (data & {{8{strb[1]}}, {8{strb[0]}}});
    end
  endfunction

  // vector address of a poll index
  function [15:0] vecFor;
    input [3:0] idx;
    begin
      case (idx)
        4'd0:    vecFor = `FLP_VEC_EXT0;
        4'd1:    vecFor = `FLP_VEC_CONV;
        4'd2:    vecFor = `FLP_VEC_TIMER0;
        4'd3:    vecFor = `FLP_VEC_EXT2;
        4'd4:    vecFor = `FLP_VEC_EXT1;
        4'd5:    vecFor = `FLP_VEC_EXT3;
        4'd6:    vecFor = `FLP_VEC_TIMER1;
        4'd7:    vecFor = `FLP_VEC_EXT4;
        4'd8:    vecFor = `FLP_VEC_SERIAL;
        4'd9:    vecFor = `FLP_VEC_EXT5;
        4'd10:   vecFor = `FLP_VEC_TIMER2;
        default: vecFor = `FLP_VEC_EXT6;
      endcase
    end
  endfunction

  // flags that the call clears by itself, in request-flag layout
  function [11:0] clearFor;
    input [3:0] idx;
    input [1:0] edgeMode;
    begin
      clearFor = 12'h000;
      case (idx)
        4'd0:    clearFor[`FLP_RQ_EXT0] = edgeMode[`FLP_CTRL_EXT0_EDGE];
        4'd2:    clearFor[`FLP_RQ_TIMER0] = 1'b1;
        4'd3:    clearFor[`FLP_RQ_EXT2] = 1'b1;
        4'd4:    clearFor[`FLP_RQ_EXT1] = edgeMode[`FLP_CTRL_EXT1_EDGE];
        4'd5:    clearFor[`FLP_RQ_EXT3] = 1'b1;
        4'd6:    clearFor[`FLP_RQ_TIMER1] = 1'b1;
        4'd7:    clearFor[`FLP_RQ_EXT4] = 1'b1;
        4'd9:    clearFor[`FLP_RQ_EXT5] = 1'b1;
        4'd11:   clearFor[`FLP_RQ_EXT6] = 1'b1;
        default: clearFor = 12'h000; // serial, timer 2 and converter stay set
      endcase
    end
  endfunction

  // true when a routine of this level or above is running
  function busyAtOrAbove;
    input [3:0] ip;
    input [1:0] lv;
    begin
      case (lv)
        2'd0:    busyAtOrAbove = |ip;
        2'd1:    busyAtOrAbove = |ip[3:1];
        2'd2:    busyAtOrAbove = |ip[3:2];
        default: busyAtOrAbove = ip[3];
      endcase
    end
  endfunction

  // clears the highest set in-progress marker
  function [3:0] dropHighest;
    input [3:0] ip;
    begin
      if (ip[3])
        dropHighest = {1'b0, ip[2:0]};
      else if (ip[2])
        dropHighest = {2'b00, ip[1:0]};
      else if (ip[1])
        dropHighest = {3'b000, ip[0]};
      else
        dropHighest = 4'h0;
    end
  endfunction

  // bus slave handshakes
  wire [7:0] wIdx    = indexOf(awAddr);
  wire [15:0] reqMerge = merge16({4'h0, reqFlags}, wData[15:0], wStrb[1:0]);
  wire       doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire wrSerial = doWrite && wIdx == `FLP_IDX_SERIAL;
  wire wrReq    = doWrite && wIdx == `FLP_IDX_REQ_FLAGS;
  wire wrStatus = doWrite && wIdx == `FLP_IDX_IRQ_STATUS;
  wire wrMask   = doWrite && wIdx == `FLP_IDX_IRQ_MASK;
  wire wrIntReg = doWrite && (wIdx == `FLP_IDX_ENABLE_A || wIdx == `FLP_IDX_ENABLE_B ||
                              wIdx == `FLP_IDX_PRIO_LOW || wIdx == `FLP_IDX_PRIO_HIGH);

  // poll-ordered sources: even index ranks higher within its group
  wire serialReq = serialCtrl[`FLP_SER_RX] | serialCtrl[`FLP_SER_TX];
  wire timer2Req = reqFlags[`FLP_RQ_TIMER2] | reqFlags[`FLP_RQ_RELOAD2];
  assign srcRaw = {reqFlags[`FLP_RQ_EXT6], timer2Req, reqFlags[`FLP_RQ_EXT5], serialReq,
                   reqFlags[`FLP_RQ_EXT4], reqFlags[`FLP_RQ_TIMER1], reqFlags[`FLP_RQ_EXT3],
                   reqFlags[`FLP_RQ_EXT1], reqFlags[`FLP_RQ_EXT2], reqFlags[`FLP_RQ_TIMER0],
                   reqFlags[`FLP_RQ_CONV], reqFlags[`FLP_RQ_EXT0]};

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : grpEnable
      assign srcEn[2*g]   = enableA[g];
      assign srcEn[2*g+1] = enableB[g];
    end
  endgenerate

  flp_poll_arbiter #(
    .NGRP (6)
  ) arbiter (
    .request   (sampled),
    .levelLow  (prioLow),
    .levelHigh (prioHigh),
    .found     (found),
    .winIndex  (winIndex),
    .winLevel  (winLevel)
  );

  // call decision in the poll cycle
  wire tryCall = pollPoint && lastCycle && !instrIsReti && !instrWritesIntReg && !busHold;
  wire wakeCall = tryCall && wakeSampled;
  wire grpCall = tryCall && !wakeSampled && found && !busyAtOrAbove(inProgress, winLevel);
  wire blockedPoll = pollPoint && (found || wakeSampled) && !wakeCall && !grpCall;
  assign vecClear = grpCall ? clearFor(winIndex, extEdge) : 12'h000;

  // hardware set events in request-flag layout
  assign events = {extEvent, converterDone, timer2Reload, timer2Ovf, timer1Ovf,
                   extEdge[`FLP_CTRL_EXT1_EDGE] & ext1Prev & ~ext1PinN,
                   timer0Ovf,
                   extEdge[`FLP_CTRL_EXT0_EDGE] & ext0Prev & ~ext0PinN};

  always @* begin
    next_serialCtrl = wrSerial && wStrb[0] ? wData[7:0] : serialCtrl;
    next_serialCtrl[`FLP_SER_TX] = next_serialCtrl[`FLP_SER_TX] | serialTxDone;
    next_serialCtrl[`FLP_SER_RX] = next_serialCtrl[`FLP_SER_RX] | serialRxDone;
    next_reqFlags = wrReq ? reqMerge[11:0] : reqFlags;
    next_reqFlags = (next_reqFlags & ~vecClear) | events;
    if (!extEdge[`FLP_CTRL_EXT0_EDGE])
      next_reqFlags[`FLP_RQ_EXT0] = ~ext0PinN;
    if (!extEdge[`FLP_CTRL_EXT1_EDGE])
      next_reqFlags[`FLP_RQ_EXT1] = ~ext1PinN;
    next_inProgress = retiExec ? dropHighest(inProgress) : inProgress;
    if (grpCall)
      next_inProgress[winLevel] = 1'b1;
    next_irqStatus = irqStatus & ~(wrStatus ? wData[2:0] & {3{wStrb[0]}} : 3'h0);
    next_irqStatus[`FLP_IRQ_CALL]    = next_irqStatus[`FLP_IRQ_CALL] | grpCall | wakeCall;
    next_irqStatus[`FLP_IRQ_BLOCKED] = next_irqStatus[`FLP_IRQ_BLOCKED] | blockedPoll;
    next_irqStatus[`FLP_IRQ_RETURN]  = next_irqStatus[`FLP_IRQ_RETURN] | retiExec;
    next_irqMask = (wrMask && wStrb[0]) ? wData[2:0] : irqMask;
  end

  always @* begin
    case (indexOf(s_axi_araddr))
      `FLP_IDX_SERIAL:     readData = {24'h0, serialCtrl};
      `FLP_IDX_PRIO_LOW:   readData = {26'h0, prioLow};
      `FLP_IDX_PRIO_HIGH:  readData = {26'h0, prioHigh};
      `FLP_IDX_ENABLE_A:   readData = {24'h0, enableA};
      `FLP_IDX_ENABLE_B:   readData = {26'h0, enableB};
      `FLP_IDX_REQ_FLAGS:  readData = {20'h0, reqFlags};
      `FLP_IDX_EXT_CTRL:   readData = {30'h0, extEdge};
      `FLP_IDX_IRQ_STATUS: readData = {29'h0, irqStatus};
      `FLP_IDX_IRQ_MASK:   readData = {29'h0, irqMask};
      `FLP_IDX_CORE_STATE: readData = {8'h0, vectorAddr, 4'h0, inProgress};
      default:             readData = 32'h0;
    endcase
  end

  // bus channels
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= {ADDR_W{1'b0}};
      wData        <= 32'h0;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FLP_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `FLP_RESP_OKAY;
      s_axi_rdata  <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(wIdx) ? `FLP_RESP_OKAY : `FLP_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= readData;
        s_axi_rresp  <= isMapped(indexOf(s_axi_araddr)) ? `FLP_RESP_OKAY : `FLP_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // registers, sampling and call issue
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      serialCtrl  <= `FLP_RST_SERIAL;
      prioLow     <= `FLP_RST_PRIO;
      prioHigh    <= `FLP_RST_PRIO;
      enableA     <= `FLP_RST_ENABLE_A;
      enableB     <= `FLP_RST_ENABLE_B;
      reqFlags    <= `FLP_RST_REQ_FLAGS;
      extEdge     <= `FLP_RST_EXT_CTRL;
      irqStatus   <= `FLP_RST_IRQ;
      irqMask     <= `FLP_RST_IRQ;
      irq         <= 1'b0;
      inProgress  <= 4'h0;
      sampled     <= 12'h000;
      wakeSampled <= 1'b0;
      busHold     <= 1'b0;
      ext0Prev    <= 1'b1;
      ext1Prev    <= 1'b1;
      longCallReq <= 1'b0;
      vectorAddr  <= 16'h0000;
    end else begin
      serialCtrl <= next_serialCtrl;
      reqFlags   <= next_reqFlags;
      inProgress <= next_inProgress;
      irqStatus  <= next_irqStatus;
      irqMask    <= next_irqMask;
      irq        <= |(next_irqStatus & next_irqMask);
      ext0Prev   <= ext0PinN;
      ext1Prev   <= ext1PinN;
      if (doWrite && wStrb[0]) begin
        case (wIdx)
          `FLP_IDX_PRIO_LOW:  prioLow  <= wData[5:0];
          `FLP_IDX_PRIO_HIGH: prioHigh <= wData[5:0];
          `FLP_IDX_ENABLE_A:  enableA  <= wData[7:0];
          `FLP_IDX_ENABLE_B:  enableB  <= wData[5:0];
          `FLP_IDX_EXT_CTRL:  extEdge  <= wData[1:0];
          default:            extEdge  <= extEdge;
        endcase
      end
      // samples are overwritten every machine cycle, nothing pending is kept
      if (samplePoint) begin
        sampled     <= srcRaw & srcEn & {12{enableA[`FLP_EN_GLOBAL]}};
        wakeSampled <= wakeUpReq;
      end
      // a bus write to enable or priority lets the current instruction finish plus one more
      if (wrIntReg)
        busHold <= 1'b1;
      else if (pollPoint && lastCycle)
        busHold <= 1'b0;
      longCallReq <= grpCall || wakeCall;
      if (wakeCall)
        vectorAddr <= `FLP_VEC_WAKE;
      else if (grpCall)
        vectorAddr <= vecFor(winIndex);
    end
  end
endmodule // flp_prioritizer

// ---- rtl/flp_regs.vh ----
// register map, field layout, reset values and vector addresses of the interrupt prioritizer
`ifndef FLP_REGS_VH
`define FLP_REGS_VH

// register indices; the byte address is four times the index
`define FLP_IDX_SERIAL      8'h98
`define FLP_IDX_PRIO_LOW    8'ha9
`define FLP_IDX_PRIO_HIGH   8'hb9
`define FLP_IDX_ENABLE_A    8'hc0
`define FLP_IDX_ENABLE_B    8'hc1
`define FLP_IDX_REQ_FLAGS   8'hc2
`define FLP_IDX_EXT_CTRL    8'hc3
`define FLP_IDX_IRQ_STATUS  8'hc4
`define FLP_IDX_IRQ_MASK    8'hc5
`define FLP_IDX_CORE_STATE  8'hc6

// reset values
`define FLP_RST_SERIAL      8'h00
`define FLP_RST_PRIO        6'h00
`define FLP_RST_ENABLE_A    8'h00
`define FLP_RST_ENABLE_B    6'h00
`define FLP_RST_REQ_FLAGS   12'h000
`define FLP_RST_EXT_CTRL    2'h0
`define FLP_RST_IRQ         3'h0

// field positions
`define FLP_SER_RX          0
`define FLP_SER_TX          1
`define FLP_EN_GLOBAL       7
`define FLP_CTRL_EXT0_EDGE  0
`define FLP_CTRL_EXT1_EDGE  1
`define FLP_IRQ_CALL        0
`define FLP_IRQ_BLOCKED     1
`define FLP_IRQ_RETURN      2
`define FLP_RQ_EXT0         0
`define FLP_RQ_TIMER0       1
`define FLP_RQ_EXT1         2
`define FLP_RQ_TIMER1       3
`define FLP_RQ_TIMER2       4
`define FLP_RQ_RELOAD2      5
`define FLP_RQ_CONV         6
`define FLP_RQ_EXT2         7
`define FLP_RQ_EXT3         8
`define FLP_RQ_EXT4         9
`define FLP_RQ_EXT5         10
`define FLP_RQ_EXT6         11

// vector addresses
`define FLP_VEC_EXT0        16'h0003
`define FLP_VEC_TIMER0      16'h000b
`define FLP_VEC_EXT1        16'h0013
`define FLP_VEC_TIMER1      16'h001b
`define FLP_VEC_SERIAL      16'h0023
`define FLP_VEC_TIMER2      16'h002b
`define FLP_VEC_CONV        16'h0043
`define FLP_VEC_EXT2        16'h004b
`define FLP_VEC_EXT3        16'h0053
`define FLP_VEC_EXT4        16'h005b
`define FLP_VEC_EXT5        16'h0063
`define FLP_VEC_EXT6        16'h006b
`define FLP_VEC_WAKE        16'h007b

// bus responses
`define FLP_RESP_OKAY       2'b00
`define FLP_RESP_SLVERR     2'b10

`endif

// ---- tb/flp_checker.sv ----
// port assertions for the interrupt prioritizer
module flp_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        pollPoint,
  input wire logic        lastCycle,
  input wire logic        instrIsReti,
  input wire logic        instrWritesIntReg,
  input wire logic        longCallReq,
  input wire logic [15:0] vectorAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic okPoll;
  // remembers whether the previous edge carried an unblocked poll
  always_ff @(posedge clk or posedge rst)
    if (rst)
      okPoll <= 1'h0;
    else
      okPoll <= pollPoint && lastCycle && !instrIsReti && !instrWritesIntReg;
  sequence s_bad_poll;
    pollPoint && (!lastCycle || instrIsReti || instrWritesIntReg);
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_call_cause; longCallReq |-> okPoll; endproperty
  a_call_cause: assert property (p_call_cause) else $error("call without open poll");
  property p_blocked; s_bad_poll |=> !longCallReq; endproperty
  a_blocked: assert property (p_blocked) else $error("call after blocked poll");
  property p_vec_hold; !longCallReq |-> $stable(vectorAddr); endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved without call");
  property p_vec_legal; longCallReq |-> vectorAddr[2:0] == 3'h3 && vectorAddr <= 16'h007b && vectorAddr[7:4] != 4'h3; endproperty
  a_vec_legal: assert property (p_vec_legal) else $error("vector not in table");
  property p_wr_resp; s_wr_taken |=> ##1 s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  property p_w_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_busy: assert property (p_w_busy) else $error("write taken during response");
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("no read response");
  property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_busy: assert property (p_r_busy) else $error("read taken during response");
endmodule // flp_checker

bind flp_prioritizer flp_checker flp_checker_i (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pollPoint, .lastCycle,
  .instrIsReti, .instrWritesIntReg, .longCallReq, .vectorAddr);

// ---- tb/flp_core_model.sv ----
// core model: machine-cycle timing of four clocks, instruction ends and returns
module flp_core_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic longInstr,
  input  wire logic retiReq,
  input  wire logic wrReq,
  output logic      samplePoint,
  output logic      pollPoint,
  output logic      lastCycle,
  output logic      instrIsReti,
  output logic      instrWritesIntReg,
  output logic      retiExec
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase;
  logic       retiPend;
  logic       wrPend;
  wire        instrEnd = pollPoint && lastCycle;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {phase, samplePoint, pollPoint, retiPend, wrPend, instrIsReti, instrWritesIntReg, retiExec} <= '0;
      lastCycle <= 1'h1;
    end else begin
      phase <= phase + 2'h1;
      samplePoint <= phase == 2'h1;
      pollPoint <= phase == 2'h3;
      retiPend <= retiReq || (retiPend && !instrEnd);
      wrPend <= wrReq || (wrPend && !instrEnd);
      retiExec <= instrEnd && instrIsReti;
      if (instrEnd) begin
        lastCycle <= !longInstr;
        instrIsReti <= retiPend;
        instrWritesIntReg <= wrPend;
      end else if (pollPoint) begin
        lastCycle <= 1'h1;
      end
    end
  end
endmodule // flp_core_model

// ---- tb/tb_flp_prioritizer.sv ----
// bench for the interrupt prioritizer driven by a core model
module tb_flp_prioritizer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] SER = 12'h260, PHI = 12'h2e4, PLO = 12'h2a4, ENA = 12'h300, ENB = 12'h304;
  localparam logic [11:0] FLG = 12'h308, CTL = 12'h30c, STS = 12'h310, MSK = 12'h314, CORE = 12'h318;
  logic        clk;
  logic        rst = 1'h1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        irq, longCallReq, samplePoint, pollPoint, lastCycle, instrIsReti, instrWritesIntReg, retiExec;
  logic [15:0] vectorAddr;
  logic        longInstr = 1'h0, retiReq = 1'h0, wrReq = 1'h0, wake = 1'h0, pin0 = 1'h1, pin1 = 1'h1;
  logic [8:0]  src = '0;
  logic [4:0]  ext = '0;
  int          error_cnt = 0, cmp_count = 0;

  flp_core_model flp_core_model_i (.clk, .rst, .longInstr, .retiReq, .wrReq, .samplePoint, .pollPoint,
    .lastCycle, .instrIsReti, .instrWritesIntReg, .retiExec);
  flp_prioritizer flp_prioritizer_i (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
    .samplePoint, .pollPoint, .lastCycle, .instrIsReti, .instrWritesIntReg, .retiExec, .wakeUpReq(wake),
    .longCallReq, .vectorAddr, .serialTxDone(src[4]), .serialRxDone(src[5]), .timer0Ovf(src[1]),
    .timer1Ovf(src[3]), .timer2Ovf(src[6]), .timer2Reload(src[7]), .converterDone(src[8]), .extEvent(ext),
    .ext0PinN(pin0), .ext1PinN(pin1));

  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      error_cnt++;
      conclude();
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 200 && !(s_axi_bvalid && s_axi_bready); n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    tmo(n);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask
  task automatic axr(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 200 && !(s_axi_rvalid && s_axi_rready); n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    tmo(n);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    chk(s_axi_rresp, er);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    axr(a, 2'h0, d);
    chk(d, e);
  endtask
  task automatic waitCall(input logic [15:0] v);
    int n;
    for (n = 0; n < 200 && !longCallReq; n++)
      @(posedge clk);
    tmo(n);
    chk(vectorAddr, v);
  endtask
  task automatic quiet(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      c += longCallReq;
    end
  endtask
  task automatic return_from_interrupt;
    @(posedge clk);
    retiReq <= 1'h1;
    @(posedge clk);
    retiReq <= 1'h0;
  endtask
  // one source event; pins pulse low for a single clock, wake stays until served
  task automatic fire(input int k);
    @(posedge clk);
    case (k)
      0: pin0 <= 1'h0;
      2: pin1 <= 1'h0;
      14: wake <= 1'h1;
      default: if (k < 9) src[k] <= 1'h1; else ext[k-9] <= 1'h1;
    endcase
    @(posedge clk);
    {src, ext, pin0, pin1} <= {14'h0, 2'h3};
  endtask

  task automatic t_reset;
    logic [31:0] d;
    rdc(SER, 32'h0);
    rdc(PLO, 32'h0);
    rdc(FLG, 32'h0);
    axr(12'h0fc, 2'h2, d);
    chk(d, 32'h0);
    axw(12'h0fc, 32'h1, 2'h2);
  endtask
  // every source alone at level 0: vector, then which flags survive the call
  task automatic t_vectors;
    logic [31:0] s, f;
    logic [15:0] v;
    logic [13:0] e;
    int c;
    axw(ENA, 32'hbf, 2'h0);
    axw(ENB, 32'h3f, 2'h0);
    axw(CTL, 32'h3, 2'h0);
    for (int k = 0; k < 15; k++) begin
      v = k < 4 ? 16'(3 + 8 * k) : k < 6 ? 16'h23 : k < 8 ? 16'h2b : k == 14 ? 16'h7b : 16'(16'h43 + 8 * (k - 8));
      e = k == 4 ? 14'h2000 : k == 5 ? 14'h1000 : (k > 5 && k < 9) ? 14'(14'h10 << (k - 6)) : 14'h0;
      fire(k);
      waitCall(v);
      wake <= 1'h0;
      axr(SER, 2'h0, s);
      axr(FLG, 2'h0, f);
      chk({s[1:0], f[11:0]}, e);
      axw(SER, 32'h0, 2'h0);
      axw(FLG, 32'h0, 2'h0);
      return_from_interrupt();
      quiet(32, c);
      chk(c, 0);
    end
  endtask
  // level 3 wins, blocks level 0, and a dropped request is forgotten
  task automatic t_levels;
    int c;
    longInstr <= 1'h1;
    axw(PHI, 32'h20, 2'h0);
    axw(PLO, 32'h20, 2'h0);
    axw(CTL, 32'h0, 2'h0);
    @(posedge clk);
    src <= 9'h04a;
    @(posedge clk);
    src <= 9'h0;
    waitCall(16'h002b);
    rdc(CORE, 32'h2b08);
    pin0 <= 1'h0;
    quiet(40, c);
    chk(c, 0);
    pin0 <= 1'h1;
    axw(FLG, 32'ha, 2'h0);
    return_from_interrupt();
    waitCall(16'h000b);
    rdc(CORE, 32'h0b01);
    return_from_interrupt();
    waitCall(16'h001b);
    return_from_interrupt();
    axw(PHI, 32'h0, 2'h0);
    longInstr <= 1'h0;
  endtask
  task automatic t_irq;
    axw(STS, 32'h7, 2'h0);
    axw(MSK, 32'h1, 2'h0);
    chk(irq, 1'h0);
    wrReq <= 1'h1;
    fire(1);
    wrReq <= 1'h0;
    waitCall(16'h000b);
    repeat (2) @(posedge clk);
    chk(irq, 1'h1);
    axw(MSK, 32'h0, 2'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'h0);
    axw(MSK, 32'h1, 2'h0);
    axw(STS, 32'h1, 2'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'h0);
    return_from_interrupt();
  endtask

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_vectors();
    t_levels();
    t_irq();
    conclude();
  end
endmodule // tb_flp_prioritizer
